/* File: verilog/pccs_clock_select.sv */
// Overview of operation
// - Host mode uses reference clock as primary.
// - Agent mode uses bus clock as primary.
// - Primary clock feeds divide-by-two, then output muxes.
// - Strap picks full or half sync output.
// - Per-output register bit picks full or half.
module pccs_clock_select (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // Avalon-MM slave
    input wire pccs_pkg::pccs_av_req_t av_req_in,
    output pccs_pkg::pccs_av_rsp_t av_rsp_out,
    // Straps and clock pins
    input wire logic host_mode_strap_in,
    input wire logic sync_out_divide_strap_in,
    input wire logic primary_ref_clock_in,
    input wire logic bus_clock_in,
    input wire logic sync_clock_in,
    // Clock outputs
    output logic sync_clock_out,
    output logic [pccs_pkg::PCCS_NUM_OUTS-1:0] bus_clock_out
);
    import pccs_pkg::*;

    localparam int N = PCCS_NUM_OUTS;

    // Input synchronisers
    logic [4:0] sy1_q, sy1_d, sy2_q, sy2_d;
    logic ref_s, bus_s, host_s, div_s, syncin_s;

    always_comb begin
        sy1_d = {sync_clock_in, sync_out_divide_strap_in, host_mode_strap_in,
                 bus_clock_in, primary_ref_clock_in};
        sy2_d = sy1_q;
    end

    always_ff @(posedge sys_clk_in) begin
        sy1_q <= sy1_d;
        sy2_q <= sy2_d;
    end

    assign ref_s = sy2_q[0];
    assign bus_s = sy2_q[1];
    assign host_s = sy2_q[2];
    assign div_s = sy2_q[3];
    assign syncin_s = sy2_q[4];

    // Strap capture after reset release
    pccs_cap_state_t cap_q, cap_d;
    logic host_q, host_d;

    always_comb begin
        cap_d = cap_q;
        host_d = host_q;
        case (cap_q)
            PCCS_CAP_WAIT: cap_d = PCCS_CAP_SAMPLE;
            PCCS_CAP_SAMPLE: begin
                host_d = host_s;
                cap_d = PCCS_CAP_DONE;
            end
            PCCS_CAP_DONE: cap_d = PCCS_CAP_DONE;
            default: cap_d = PCCS_CAP_WAIT;
        endcase
        if (!resetn_in) begin
            cap_d = PCCS_CAP_WAIT;
            host_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        cap_q <= cap_d;
        host_q <= host_d;
    end

    // Primary source, divider and output muxes
    logic prim_q, prim_d, half_q, half_d, quiet;
    logic sync_sel_q, sync_sel_d, sync_q, sync_d;
    logic [N-1:0] occ_q, occ_d, sel_q, sel_d, out_q, out_d;

    assign quiet = !prim_q && !half_q;

    always_comb begin
        prim_d = host_q ? ref_s : bus_s;
        half_d = (prim_d && !prim_q) ? !half_q : half_q;
        sync_sel_d = quiet ? div_s : sync_sel_q;
        sync_d = sync_sel_q ? half_q : prim_q;
        if (!resetn_in) begin
            prim_d = 1'b0;
            half_d = 1'b0;
            sync_sel_d = 1'b0;
            sync_d = 1'b0;
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_out
        always_comb begin
            sel_d[i] = quiet ? occ_q[i] : sel_q[i];
            out_d[i] = sel_q[i] ? half_q : prim_q;
            if (!resetn_in) begin
                sel_d[i] = 1'b0;
                out_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        prim_q <= prim_d;
        half_q <= half_d;
        sync_sel_q <= sync_sel_d;
        sync_q <= sync_d;
        sel_q <= sel_d;
        out_q <= out_d;
    end

    assign sync_clock_out = sync_q;
    assign bus_clock_out = out_q;

    // Avalon-MM slave, one wait cycle
    logic ack_q, ack_d;
    logic [31:0] rd_q, rd_d;
    logic req, hit;
    logic [31:0] status;

    assign req = av_req_in.read || av_req_in.write;
    assign hit = req && !ack_q;

    always_comb begin
        status = 32'h0000_0000;
        status[PCCS_ST_HOST] = host_q;
        status[PCCS_ST_SYNC_HALF] = sync_sel_q;
        status[PCCS_ST_SYNC_IN] = syncin_s;
        status[PCCS_ST_SEL_LSB +: N] = sel_q;
    end

    always_comb begin
        ack_d = hit;
        occ_d = occ_q;
        rd_d = rd_q;
        if (ack_q && av_req_in.write && av_req_in.address == PCCS_OFS_OCC) begin
            occ_d = av_req_in.writedata[N-1:0];
        end
        if (hit && av_req_in.read) begin
            case (av_req_in.address)
                PCCS_OFS_OCC: rd_d = {{(32-N){1'b0}}, occ_q};
                PCCS_OFS_STATUS: rd_d = status;
                default: rd_d = PCCS_UNMAPPED_RD;
            endcase
        end
        if (!resetn_in) begin
            ack_d = 1'b0;
            occ_d = PCCS_OCC_RST;
            rd_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        ack_q <= ack_d;
        occ_q <= occ_d;
        rd_q <= rd_d;
    end

    assign av_rsp_out = '{waitrequest: !ack_q, readdata: rd_q};

    // Checks
    host_src_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && host_q && $past(host_q) |-> prim_q == $past(ref_s))
        else $error("host mode primary not reference clock");
    agent_src_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && !host_q && !$past(host_q) |-> prim_q == $past(bus_s))
        else $error("agent mode primary not bus clock");
    half_div_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && $rose(prim_q) |-> half_q != $past(half_q))
        else $error("divider missed a primary rising edge");
    half_hold_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && !$rose(prim_q) |-> $stable(half_q))
        else $error("divider toggled without primary edge");

    sequence pccs_sel_change_s;
        $past(resetn_in) ##0 !$stable(sel_q);
    endsequence

    sequence pccs_cap_done_s;
        $past(resetn_in) ##0 $past(cap_q) == PCCS_CAP_DONE;
    endsequence

    sel_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        pccs_sel_change_s |-> $past(quiet))
        else $error("output select changed while sources active");
    sync_mux_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) |-> sync_clock_out == ($past(sync_sel_q) ? $past(half_q) : $past(prim_q)))
        else $error("sync output mux wrong");
    out_mux_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) |-> bus_clock_out[0] == ($past(sel_q[0]) ? $past(half_q) : $past(prim_q)))
        else $error("bus clock output mux wrong");
    sel_load_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && $past(quiet) |-> sel_q == $past(occ_q))
        else $error("output select not loaded when quiet");
    bus_ans_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        hit |=> !av_rsp_out.waitrequest)
        else $error("bus answer late");
    bus_idle_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !hit |=> av_rsp_out.waitrequest)
        else $error("bus answered without request");
    host_hold_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        pccs_cap_done_s |-> $stable(host_q))
        else $error("host strap changed after capture");
    sync_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && !$stable(sync_sel_q) |-> $past(quiet))
        else $error("sync select changed while sources active");
    sync_load_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && $past(quiet) |-> sync_sel_q == $past(div_s))
        else $error("sync select not loaded when quiet");
    quiet_out_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $past(resetn_in) && $past(quiet) |-> !sync_clock_out && bus_clock_out == '0)
        else $error("outputs not low in quiet moment");
endmodule

/* File: verilog/pccs_pkg.sv */
package pccs_pkg;
    // Bus clock output count and register map
    localparam int PCCS_NUM_OUTS = 5;
    localparam int PCCS_ADDR_W = 4;
    localparam logic [3:0] PCCS_OFS_OCC = 4'h0;
    localparam logic [3:0] PCCS_OFS_STATUS = 4'h4;
    localparam logic [4:0] PCCS_OCC_RST = 5'h00;
    // Status field positions
    localparam int PCCS_ST_HOST = 0;
    localparam int PCCS_ST_SYNC_HALF = 1;
    localparam int PCCS_ST_SYNC_IN = 2;
    localparam int PCCS_ST_SEL_LSB = 8;
    localparam logic [31:0] PCCS_UNMAPPED_RD = 32'h0000_0000;

    typedef struct packed {
        logic read;
        logic write;
        logic [PCCS_ADDR_W-1:0] address;
        logic [31:0] writedata;
    } pccs_av_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } pccs_av_rsp_t;

    typedef enum logic [1:0] {
        PCCS_CAP_WAIT,
        PCCS_CAP_SAMPLE,
        PCCS_CAP_DONE
    } pccs_cap_state_t;
endpackage

/* File: tb/pccs_board_model.sv */
module pccs_board_model (
    // Clock and straps
    input wire logic sys_clk_in,
    input wire logic host_mode_in,
    // Loop-back pins
    input wire logic sync_loop_in,
    output logic sync_loop_out,
    // Primary clock pins
    output logic ref_clk_out,
    output logic bus_clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slow = 1'b0;
    // Slow clock, 16 system periods, off the system edges
    initial begin
        #3;
        forever #80 slow = ~slow;
    end
    assign ref_clk_out = host_mode_in ? slow : 1'b0;
    assign bus_clk_out = host_mode_in ? 1'b0 : slow;
    assign sync_loop_out = sync_loop_in;
endmodule

/* File: tb/pci_clock_source_select_bench.sv */
module pci_clock_source_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pccs_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, host = 1'b1, half = 1'b0;
    logic ref_clk, bus_clk, sync_in, sync_out;
    logic [PCCS_NUM_OUTS-1:0] bco;
    pccs_av_req_t req = '0;
    pccs_av_rsp_t rsp;
    int num_errors = 0, samples_checked = 0;
    int n_edge[6];
    bit cnt_en = 0;
    logic [5:0] prv = '0;
    logic [31:0] rd;
    logic [5:0] taps;
    // Board clock plan in MHz
    localparam int CSB_MHZ = 200, LBIU_MHZ = 200, LCLK_DIV = 4;
    localparam int MEM_MHZ = 200, CRYPTO_MHZ = 133;
    assign taps = {bco, sync_out};
    initial forever #5 clk = ~clk;
    pccs_clock_select pccs_clock_select_i (.sys_clk_in(clk), .resetn_in(resetn),
        .av_req_in(req), .av_rsp_out(rsp), .host_mode_strap_in(host),
        .sync_out_divide_strap_in(half), .primary_ref_clock_in(ref_clk),
        .bus_clock_in(bus_clk), .sync_clock_in(sync_in), .sync_clock_out(sync_out),
        .bus_clock_out(bco));
    pccs_board_model pccs_board_model_i (.sys_clk_in(clk), .host_mode_in(host),
        .sync_loop_in(sync_out), .sync_loop_out(sync_in), .ref_clk_out(ref_clk),
        .bus_clk_out(bus_clk));
    always @(posedge clk) begin
        for (int k = 0; k < 6; k++)
            if (cnt_en && taps[k] && !prv[k]) n_edge[k]++;
        prv <= taps;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int e, input int g);
        samples_checked++;
        if (g < e - 1 || g > e + 1) begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk);
        req <= '{read: r, write: !r, address: a, writedata: wd};
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req <= '0;
    endtask
    task automatic restart(input logic h, input logic hf);
        @(posedge clk);
        resetn <= 1'b0;
        host <= h;
        half <= hf;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic measure();
        repeat (32) @(posedge clk);
        n_edge = '{default: 0};
        cnt_en = 1;
        repeat (320) @(posedge clk);
        cnt_en = 0;
    endtask
    task automatic s_host(input logic hf);
        restart(1'b1, hf);
        bus(1'b0, PCCS_OFS_OCC, 32'h0000_000A);
        repeat (40) @(posedge clk);
        bus(1'b1, PCCS_OFS_OCC, 32'h0);
        chk("occ", 32'h0000_000A, rd);
        bus(1'b1, PCCS_OFS_STATUS, 32'h0);
        chk("status", {19'h0, 5'h0A, 6'h0, hf, 1'b1}, rd & 32'hFFFF_FFFB);
        measure();
        chk_rng("sync_edges", hf ? 10 : 20, n_edge[0]);
        chk_rng("bus0_edges", 20, n_edge[1]);
        chk_rng("bus1_edges", 10, n_edge[2]);
        chk_rng("bus3_edges", 10, n_edge[4]);
    endtask
    task automatic s_regs();
        bus(1'b0, PCCS_OFS_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, 4'hC, 32'hFFFF_FFFF);
        bus(1'b1, PCCS_OFS_OCC, 32'h0);
        chk("occ_kept", 32'h0000_000A, rd);
        bus(1'b1, 4'hC, 32'h0);
        chk("unmapped", PCCS_UNMAPPED_RD, rd);
        bus(1'b0, PCCS_OFS_OCC, 32'hFFFF_FFFF);
        bus(1'b1, PCCS_OFS_OCC, 32'h0);
        chk("occ_width", 32'h0000_001F, rd);
    endtask
    task automatic s_agent();
        restart(1'b0, 1'b0);
        bus(1'b1, PCCS_OFS_OCC, 32'h0);
        chk("occ_reset", {27'h0, PCCS_OCC_RST}, rd);
        bus(1'b1, PCCS_OFS_STATUS, 32'h0);
        chk("agent_bit", 32'h0, rd & 32'h1);
        measure();
        chk_rng("agent_sync", 20, n_edge[0]);
        chk_rng("agent_bus4", 20, n_edge[5]);
    endtask
    task automatic s_plan();
        chk("csb_plan", 32'h1, {31'h0, (CSB_MHZ >= 100 && CSB_MHZ <= 266)});
        chk("mem_plan", 32'h1, {31'h0, (MEM_MHZ >= 100 && MEM_MHZ <= 200)});
        chk("lclk_low", 32'h1, {31'h0, (LBIU_MHZ * 100 / LCLK_DIV >= 1667)});
        chk("lclk_high", 32'h1, {31'h0, (LBIU_MHZ / LCLK_DIV <= 133)});
        chk("crypto_plan", 32'h1, {31'h0, (CRYPTO_MHZ <= 133)});
        chk("lclk_div", 32'h1, {31'h0, (LCLK_DIV == 2 || LCLK_DIV == 4 || LCLK_DIV == 8)});
        chk("lbiu_mult", 32'h1, {31'h0, (LBIU_MHZ == CSB_MHZ || LBIU_MHZ == 2 * CSB_MHZ)});
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        s_host(1'b0);
        s_regs();
        s_host(1'b1);
        s_agent();
        s_plan();
        report_and_stop();
    end
endmodule
